// ===== include/recorder_framer_pkg.sv
// Purpose: Constants, types and register map of the recorder packet framer.
// Assumes: 32-bit AHB-Lite register bus, byte-wide packet output.
// Notes: Header is six little-endian 32-bit words.
package recorder_framer_pkg;

  localparam logic [15:0] SYNC_WORD = 16'heb25;
  localparam logic [32:0] HDR_BYTES = 33'h0_0000_0018;
  localparam logic [4:0] HDR_LAST_IDX = 5'h17;
  localparam logic [32:0] MAX_PKT_BYTES = 33'h0_0008_0000;
  localparam logic [32:0] MAX_SETUP_BYTES = 33'h0_0800_0000;

  localparam logic [7:0] TYPE_SETUP = 8'h01;
  localparam logic [7:0] TYPE_INDEX = 8'h03;
  localparam logic [4:0] GROUP_COMPUTER = 5'h00;
  localparam logic [4:0] GROUP_TIME = 5'h02;
  localparam logic [7:0] VER_MIN = 8'h01;
  localparam logic [7:0] VER_MAX = 8'h06;
  localparam logic [7:0] FLAG_RSVD_MASK = 8'h10;
  localparam logic [7:0] FLAG_LOCK_MASK = 8'h0c;

  localparam int RTC_HZ = 10_000_000;
  localparam int GEN_LIMIT_MS = 100;
  localparam int COMMIT_LIMIT_MS = 1000;
  localparam logic [47:0] GEN_TICKS = 48'(GEN_LIMIT_MS * (RTC_HZ / 1000));
  localparam logic [47:0] COMMIT_TICKS = 48'(COMMIT_LIMIT_MS * (RTC_HZ / 1000));

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MUX = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ERRORS = 8'h0c;
  localparam logic [7:0] REG_PKTCOUNT = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_IDX_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [4:0] NSB_RESET = 5'h00;
  localparam logic [15:0] MUXID_RESET = 16'h0000;
  localparam int ERR_SIZE = 0;
  localparam int ERR_ORDER = 1;
  localparam int ERR_CHANNEL = 2;
  localparam int ERR_VERSION = 3;
  localparam int ERR_EMPTY = 4;
  localparam int ERR_GEN_LATE = 5;
  localparam int ERR_COMMIT_LATE = 6;
  localparam int ERR_BITS = 7;

  typedef enum logic [1:0] {
    CK_NONE = 2'b00,
    CK_8 = 2'b01,
    CK_16 = 2'b10,
    CK_32 = 2'b11
  } ckSize_t;

  typedef enum logic [1:0] {
    PH_WAIT_SETUP = 2'b00,
    PH_SETUP = 2'b01,
    PH_RUN = 2'b10,
    PH_CLOSED = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_BODY = 3'b010,
    ST_FILL = 3'b011,
    ST_CK = 3'b100
  } frame_t;

  typedef struct packed {
    logic [7:0] dataType;
    logic [15:0] channel;
    logic [7:0] version;
    logic [7:0] flags;
    logic [31:0] dataLen;
    logic [47:0] relTime;
    ckSize_t ckSize;
    logic rootIndex;
  } desc_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_t;

endpackage : recorder_framer_pkg

// ===== core/recorder_packet_framer.sv
// Purpose: Frames descriptor plus body bytes into recorder packets.
// Assumes: Source gives length up front, checksum with the final body byte.
// Notes: Refused descriptors are consumed and flagged in the error register.
//
// Summary of operation
// R01 - Checksum size none, 8, 16 or 32 bits
// R02 - Filler first, then checksum bytes LSB first
// R03 - 8-bit checksum: filler then one byte
// R04 - Whole packet at most 524,288 bytes
// R05 - Setup packets allowed up to 134,217,728 bytes
// R06 - Split data use per-channel sequence counter
// R07 - Setup first, then time, then others
// R08 - Nothing follows the root index packet
// R09 - Packet spans at most 100 ms data
// R10 - No empty or filler-only packets
// R11 - Reserved header bits written as zero
// R12 - Commit within 1,000 ms of header time
// R13 - Version and structure bits fixed per channel
// R14 - Header exactly 24 contiguous bytes
// R15 - Sync field always 0xEB25
// R16 - Two-byte channel identifier in header
// R17 - Upper channel bits carry multiplexer source
// R18 - Channel zero only for setup packets
// R19 - One packet type per channel
// R20 - Packet length four bytes, multiple of four
// R21 - Data length excludes filler and checksum
// R22 - Version code between 0x01 and 0x06
// R23 - Header in little-endian 32-bit words
// R24 - Zero to three filler bytes align length
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module recorder_packet_framer
  import recorder_framer_pkg::*;
#(
  parameter int CH_SLOTS = 16
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire desc_t desc,
  input wire logic descValid,
  output logic descReady,
  input wire logic [7:0] bodyByte,
  input wire logic bodyValid,
  output logic bodyReady,
  input wire logic [31:0] ckValue,
  input wire logic [47:0] rtc,
  output byte_t outByte,
  output logic outValid,
  input wire logic outReady,
  output logic ageAlarm
);

  localparam int SLOT_W = $clog2(CH_SLOTS);

  function automatic logic [32:0] ckBytes(input ckSize_t s);
    unique case (s)
      CK_NONE: ckBytes = 33'h0;
      CK_8: ckBytes = 33'h1;
      CK_16: ckBytes = 33'h2;
      CK_32: ckBytes = 33'h4;
    endcase
  endfunction : ckBytes

  function automatic logic [191:0] buildHdr(input logic [15:0] ch, input logic [31:0] pLen,
      input logic [31:0] dLen, input logic [7:0] ty, input logic [7:0] fl,
      input logic [7:0] sq, input logic [7:0] ver, input logic [47:0] rt);
    logic [175:0] body;
    logic [15:0] sum;
    body = {rt, ty, fl, sq, ver, dLen, pLen, ch, SYNC_WORD};
    sum = 16'h0;
    for (int i = 0; i < 11; i++)
    begin
      sum = sum + body[16*i +: 16];
    end
    buildHdr = {sum, body};
  endfunction : buildHdr

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [1:0] ctrlQ;
  logic [4:0] nsbQ;
  logic [15:0] muxIdQ;
  logic [ERR_BITS-1:0] errQ;
  logic [ERR_BITS-1:0] errSet;
  logic [31:0] pktCountQ;
  logic wrPendQ;
  logic [7:0] wrAddrQ;
  logic [31:0] statusWord;
  phase_t phaseQ;
  frame_t stateQ;
  logic busTake;

  assign busTake = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign statusWord = {27'h0, stateQ, phaseQ};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPendQ <= 1'b0;
      wrAddrQ <= 8'h00;
    end
    else
    begin
      wrPendQ <= busTake && hwrite;
      wrAddrQ <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (busTake && !hwrite)
    begin
      unique case (haddr[7:0])
        REG_CTRL: hrdata <= {30'h0, ctrlQ};
        REG_MUX: hrdata <= {muxIdQ, 11'h0, nsbQ};
        REG_STATUS: hrdata <= statusWord;
        REG_ERRORS: hrdata <= {{(32-ERR_BITS){1'b0}}, errQ};
        REG_PKTCOUNT: hrdata <= pktCountQ;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlQ <= CTRL_RESET;
      nsbQ <= NSB_RESET;
      muxIdQ <= MUXID_RESET;
    end
    else if (wrPendQ && wrAddrQ == REG_CTRL)
      ctrlQ <= hwdata[1:0];
    else if (wrPendQ && wrAddrQ == REG_MUX)
    begin
      nsbQ <= (hwdata[4:0] > 5'h10) ? 5'h10 : hwdata[4:0];
      muxIdQ <= hwdata[31:16];
    end
  end

  // Write one clears; a new event in the same cycle is kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      errQ <= '0;
    else if (wrPendQ && wrAddrQ == REG_ERRORS)
      errQ <= (errQ & ~hwdata[ERR_BITS-1:0]) | errSet;
    else
      errQ <= errQ | errSet;
  end

  ////////////////////////////////////////////////////////////////////////
  // Descriptor checks
  logic enable;
  logic isSetup;
  logic isTime;
  logic isComputer;
  logic isRoot;
  logic [15:0] keepMask;
  logic [15:0] effChan;
  logic [SLOT_W-1:0] slot;
  logic [32:0] ckB;
  logic [32:0] rawLen;
  logic [1:0] fillB;
  logic [32:0] totLen;
  logic badSize;
  logic badOrder;
  logic badChan;
  logic badVer;
  logic badEmpty;
  logic accept;
  logic start;
  logic [CH_SLOTS-1:0] slotUsedQ;
  logic [7:0] slotTypeQ [CH_SLOTS];
  logic [7:0] slotVerQ [CH_SLOTS];
  logic [7:0] slotFlagQ [CH_SLOTS];
  logic [7:0] slotSeqQ [CH_SLOTS];

  assign enable = ctrlQ[CTRL_EN_BIT];
  assign isSetup = desc.dataType == TYPE_SETUP;
  assign isTime = desc.dataType[7:3] == GROUP_TIME;
  assign isComputer = desc.dataType[7:3] == GROUP_COMPUTER;
  assign isRoot = desc.dataType == TYPE_INDEX && desc.rootIndex && ctrlQ[CTRL_IDX_BIT];
  assign keepMask = 16'hffff >> nsbQ;
  assign effChan = isSetup ? desc.channel
    : ((muxIdQ & ~keepMask) | (desc.channel & keepMask)); // R17
  assign slot = effChan[SLOT_W-1:0];
  assign ckB = ckBytes(desc.ckSize); // R01
  assign rawLen = HDR_BYTES + {1'b0, desc.dataLen} + ckB;
  assign fillB = 2'b00 - rawLen[1:0]; // R24
  assign totLen = rawLen + {31'h0, fillB};
  assign badSize = totLen > (isSetup ? MAX_SETUP_BYTES : MAX_PKT_BYTES); // R04 R05
  assign badEmpty = desc.dataLen == 32'h0; // R10
  assign badVer = desc.version < VER_MIN || desc.version > VER_MAX // R22
    || (!isSetup && slotUsedQ[slot] && (slotVerQ[slot] != desc.version // R13
    || (slotFlagQ[slot] & FLAG_LOCK_MASK) != (desc.flags & FLAG_LOCK_MASK)));
  assign badChan = (isSetup != (effChan == 16'h0000)) // R18
    || (!isSetup && slotUsedQ[slot] && slotTypeQ[slot] != desc.dataType); // R19

  always_comb
  begin
    unique case (phaseQ) // R07 R08
      PH_WAIT_SETUP: badOrder = !isSetup;
      PH_SETUP: badOrder = !isSetup && !isTime;
      PH_RUN: badOrder = isSetup;
      PH_CLOSED: badOrder = 1'b1;
    endcase
  end

  // Waits for the final byte to leave so its trailer state is not replaced under it
  assign descReady = enable && stateQ == ST_IDLE && !(outValid && outByte.last);
  assign accept = descValid && descReady;
  assign start = accept && !(badSize || badOrder || badChan || badVer || badEmpty);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phaseQ <= PH_WAIT_SETUP;
    else if (!enable)
      phaseQ <= PH_WAIT_SETUP;
    else if (start)
    begin
      if (isRoot)
        phaseQ <= PH_CLOSED; // R08
      else if (isSetup)
        phaseQ <= (phaseQ == PH_WAIT_SETUP) ? PH_SETUP : phaseQ;
      else if (phaseQ == PH_SETUP)
        phaseQ <= PH_RUN; // R07
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      slotUsedQ <= '0;
    else if (!enable)
      slotUsedQ <= '0;
    else if (start)
      slotUsedQ[slot] <= 1'b1; // R13
  end

  always_ff @(posedge clk)
  begin
    if (start)
    begin
      slotTypeQ[slot] <= desc.dataType; // R19
      slotVerQ[slot] <= desc.version;
      slotFlagQ[slot] <= desc.flags;
      slotSeqQ[slot] <= slotUsedQ[slot] ? slotSeqQ[slot] + 8'h01 : 8'h00; // R06
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Packet byte stream
  logic [191:0] hdrQ;
  logic [31:0] cntQ;
  logic [31:0] ckQ;
  logic [31:0] ckValQ;
  ckSize_t ckSizeQ;
  logic [1:0] fillQ;
  logic [47:0] relTimeQ;
  logic [31:0] pktLenQ;
  logic dynQ;
  logic [31:0] prodPosQ;
  logic [31:0] outPosQ;
  logic slotFree;
  logic produce;
  logic bodyDone;
  logic [47:0] age;
  logic [31:0] dLenQ;
  logic [31:0] ckLast;

  assign slotFree = !outValid || outReady;
  assign ckLast = 32'(ckBytes(ckSizeQ) - 33'h1);
  assign bodyReady = stateQ == ST_BODY && slotFree;
  assign bodyDone = bodyValid && bodyReady && cntQ == 32'h0;
  assign age = rtc - relTimeQ;

  always_comb
  begin
    unique case (stateQ)
      ST_IDLE: produce = 1'b0;
      ST_BODY: produce = bodyValid && slotFree;
      default: produce = slotFree;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateQ <= ST_IDLE;
      cntQ <= 32'h0;
      hdrQ <= '0;
      ckQ <= 32'h0;
    end
    else
    begin
      unique case (stateQ)
        ST_IDLE:
          if (start)
          begin
            stateQ <= ST_HDR; // R14 R16 R20 R21 R23 R11
            cntQ <= {27'h0, HDR_LAST_IDX};
            hdrQ <= buildHdr(effChan, totLen[31:0], desc.dataLen, desc.dataType,
              desc.flags & ~FLAG_RSVD_MASK, slotUsedQ[slot] ? slotSeqQ[slot] + 8'h01 : 8'h00,
              desc.version, desc.relTime);
          end
        ST_HDR:
          if (produce)
          begin
            hdrQ <= hdrQ >> 8;
            cntQ <= (cntQ == 32'h0) ? dLenQ - 32'h1 : cntQ - 32'h1;
            if (cntQ == 32'h0)
              stateQ <= ST_BODY;
          end
        ST_BODY:
          if (produce)
          begin
            cntQ <= cntQ - 32'h1;
            if (cntQ == 32'h0)
            begin
              ckQ <= ckValue;
              cntQ <= (fillQ != 2'b00) ? {30'h0, fillQ} - 32'h1 : ckLast;
              stateQ <= (fillQ != 2'b00) ? ST_FILL : (ckSizeQ != CK_NONE) ? ST_CK : ST_IDLE;
            end
          end
        ST_FILL:
          if (produce)
          begin
            cntQ <= (cntQ == 32'h0) ? ckLast : cntQ - 32'h1; // R02 R03
            if (cntQ == 32'h0)
              stateQ <= (ckSizeQ != CK_NONE) ? ST_CK : ST_IDLE;
          end
        ST_CK:
          if (produce)
          begin
            ckQ <= ckQ >> 8; // R02
            cntQ <= cntQ - 32'h1;
            if (cntQ == 32'h0)
              stateQ <= ST_IDLE;
          end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dLenQ <= 32'h0;
      pktLenQ <= 32'h0;
      fillQ <= 2'b00;
      ckSizeQ <= CK_NONE;
      relTimeQ <= 48'h0;
      dynQ <= 1'b0;
    end
    else if (start)
    begin
      dLenQ <= desc.dataLen; // R21
      pktLenQ <= totLen[31:0]; // R20
      fillQ <= fillB;
      ckSizeQ <= desc.ckSize;
      relTimeQ <= desc.relTime;
      dynQ <= !isComputer;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outByte <= '0;
      outValid <= 1'b0;
      prodPosQ <= 32'h0;
      outPosQ <= 32'h0;
      ckValQ <= 32'h0;
    end
    else
    begin
      if (start)
        prodPosQ <= 32'h0;
      else if (produce)
        prodPosQ <= prodPosQ + 32'h1;
      if (bodyDone)
        ckValQ <= ckValue;
      if (produce)
      begin
        outValid <= 1'b1;
        outPosQ <= prodPosQ;
        outByte.last <= cntQ == 32'h0 && (stateQ == ST_CK
          || (stateQ == ST_FILL && ckSizeQ == CK_NONE)
          || (stateQ == ST_BODY && fillQ == 2'b00 && ckSizeQ == CK_NONE));
        unique case (stateQ)
          ST_HDR: outByte.data <= hdrQ[7:0]; // R15 R23
          ST_BODY: outByte.data <= bodyByte;
          ST_CK: outByte.data <= ckQ[7:0];
          default: outByte.data <= 8'h00; // R24
        endcase
      end
      else if (outReady)
        outValid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing watch and counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ageAlarm <= 1'b0;
    else
      ageAlarm <= stateQ == ST_BODY && dynQ && age >= GEN_TICKS; // R09
  end

  always_comb
  begin
    errSet = '0;
    errSet[ERR_SIZE] = accept && badSize;
    errSet[ERR_ORDER] = accept && badOrder;
    errSet[ERR_CHANNEL] = accept && badChan;
    errSet[ERR_VERSION] = accept && badVer;
    errSet[ERR_EMPTY] = accept && badEmpty;
    errSet[ERR_GEN_LATE] = bodyDone && dynQ && age > GEN_TICKS; // R09
    errSet[ERR_COMMIT_LATE] = outValid && outReady && outByte.last && dynQ
      && age > COMMIT_TICKS; // R12
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pktCountQ <= 32'h0;
    else if (outValid && outReady && outByte.last)
      pktCountQ <= pktCountQ + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_syncLow;
    @(posedge clk) disable iff (!rst_n)
    outValid && outPosQ == 32'h0 |-> outByte.data == SYNC_WORD[7:0];
  endproperty
  a_syncLow: assert property (p_syncLow) else $error("sync low byte wrong"); // R15

  property p_syncHigh;
    @(posedge clk) disable iff (!rst_n)
    outValid && outPosQ == 32'h1 |-> outByte.data == SYNC_WORD[15:8];
  endproperty
  a_syncHigh: assert property (p_syncHigh) else $error("sync high byte wrong"); // R15

  property p_lenAlign;
    @(posedge clk) disable iff (!rst_n)
    outValid && outPosQ == 32'h4 |-> outByte.data[1:0] == 2'b00 && pktLenQ[1:0] == 2'b00;
  endproperty
  a_lenAlign: assert property (p_lenAlign) else $error("packet length not aligned"); // R20

  property p_version;
    @(posedge clk) disable iff (!rst_n)
    outValid && outPosQ == 32'hc |-> outByte.data >= VER_MIN && outByte.data <= VER_MAX;
  endproperty
  a_version: assert property (p_version) else $error("version out of range"); // R22

  property p_lastPos;
    @(posedge clk) disable iff (!rst_n)
    outValid && outByte.last |-> outPosQ + 32'h1 == pktLenQ && pktLenQ <= MAX_SETUP_BYTES[31:0];
  endproperty
  a_lastPos: assert property (p_lastPos) else $error("packet end misplaced"); // R05

  property p_trailer;
    @(posedge clk) disable iff (!rst_n)
    start |=> pktLenQ - dLenQ - 32'h18 - {30'h0, fillQ} == ckBytes(ckSizeQ) - 33'h0;
  endproperty
  a_trailer: assert property (p_trailer) else $error("trailer size wrong"); // R01

  property p_ck32;
    @(posedge clk) disable iff (!rst_n)
    outValid && outByte.last && ckSizeQ == CK_32 |-> outByte.data == ckValQ[31:24];
  endproperty
  a_ck32: assert property (p_ck32) else $error("checksum msb not last"); // R02

  property p_ck8;
    @(posedge clk) disable iff (!rst_n)
    outValid && outByte.last && ckSizeQ == CK_8 |-> outByte.data == ckValQ[7:0];
  endproperty
  a_ck8: assert property (p_ck8) else $error("8-bit checksum wrong"); // R03

  property p_closed;
    @(posedge clk) disable iff (!rst_n)
    phaseQ == PH_CLOSED && enable |-> !start;
  endproperty
  a_closed: assert property (p_closed) else $error("packet after root index"); // R08

  property p_firstSetup;
    @(posedge clk) disable iff (!rst_n)
    start && phaseQ == PH_WAIT_SETUP |-> isSetup ##1 phaseQ == PH_SETUP || phaseQ == PH_CLOSED;
  endproperty
  a_firstSetup: assert property (p_firstSetup) else $error("recording not opened by setup"); // R07

  property p_nonEmpty;
    @(posedge clk) disable iff (!rst_n)
    start |-> desc.dataLen != 32'h0 ##1 stateQ == ST_HDR;
  endproperty
  a_nonEmpty: assert property (p_nonEmpty) else $error("empty packet started"); // R10

  c_split: cover property (@(posedge clk) disable iff (!rst_n) start && slotUsedQ[slot]);
  c_fill3: cover property (@(posedge clk) disable iff (!rst_n) start && fillB == 2'b11);
  c_refused: cover property (@(posedge clk) disable iff (!rst_n) accept && !start);
  c_root: cover property (@(posedge clk) disable iff (!rst_n) start && isRoot);

endmodule : recorder_packet_framer

// ===== sim/stream_sink.sv
// Purpose: Stream consumer model that takes framed packet bytes.
// Assumes: Byte handshake on outValid and outReady.
// Notes: With slow high it accepts only every other cycle.
`timescale 1ns/1ps
module stream_sink
  import recorder_framer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire byte_t outByte,
  input wire logic outValid,
  output logic outReady,
  input wire logic slow
);
  byte_t rxQ[$];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outReady <= 1'b0;
    end
    else
    begin
      if (outValid && outReady)
      begin
        rxQ.push_back(outByte);
      end
      outReady <= slow ? !outReady : 1'b1;
    end
  end
endmodule : stream_sink

// ===== sim/recorder_packet_framer_tb.sv
// Purpose: Self-checking bench for the recorder packet framer.
// Assumes: Registers over AHB-Lite, stream sink model on the output.
// Notes: Expected packets are built from the descriptor fields.
`timescale 1ns/1ps
module recorder_packet_framer_tb
  import recorder_framer_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, descReady, bodyReady, outValid, outReady, ageAlarm;
  logic [31:0] hrdata;
  logic [31:0] snap;
  desc_t desc = '0;
  desc_t d;
  logic descValid = 1'b0;
  logic [7:0] bodyByte = 8'h00;
  logic bodyValid = 1'b0;
  logic [31:0] ckValue = 32'h0;
  logic [47:0] rtc = 48'h0000_0000_1000;
  logic slow = 1'b0;
  byte_t outByte;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] expQ[$];
  logic [15:0] muxExp = 16'h0000;

  always #2.5 clk = ~clk;

  recorder_packet_framer #(.CH_SLOTS(16)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .desc(desc),
    .descValid(descValid), .descReady(descReady), .bodyByte(bodyByte),
    .bodyValid(bodyValid), .bodyReady(bodyReady), .ckValue(ckValue), .rtc(rtc),
    .outByte(outByte), .outValid(outValid), .outReady(outReady), .ageAlarm(ageAlarm));

  stream_sink consumer (.clk(clk), .rst_n(rst_n), .outByte(outByte), .outValid(outValid),
    .outReady(outReady), .slow(slow));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic rdy(input int s);
    case (s)
      0: return hreadyout;
      1: return descReady;
      2: return bodyReady;
      default: return consumer.rxQ.size() > 0 && consumer.rxQ[$].last;
    endcase
  endfunction : rdy

  // Waits for a ready condition and returns on the edge that takes it
  task automatic handshake(input int s);
    int n;
    n = 0;
    @(negedge clk);
    while (rdy(s) !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 5000)
      begin
        failures++;
        tally_and_finish();
      end
    end
    @(posedge clk);
    snap = hrdata;
  endtask : handshake

  ////////////////////////////////////////////////////////////////////////////////
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    handshake(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    handshake(0);
  endtask : ahb

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(snap, exp);
  endtask : rdChk

  function automatic desc_t mk(input logic [7:0] ty, input logic [15:0] ch,
    input logic [7:0] v, input logic [31:0] n, input ckSize_t c);
    return '{ty, ch, v, 8'h00, n, 48'h0000_0000_1000, c, ty == TYPE_INDEX};
  endfunction : mk

  function automatic void put32(input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      expQ.push_back(w[8*i +: 8]);
  endfunction : put32

  task automatic sendPkt(input desc_t dd, input logic skip);
    logic late;
    desc <= dd;
    descValid <= 1'b1;
    ckValue <= 32'h8a3c_51e7;
    handshake(1);
    descValid <= 1'b0;
    for (int i = 0; !skip && i < dd.dataLen; i++)
    begin
      bodyByte <= 8'(i) ^ 8'h5a;
      bodyValid <= 1'b1;
      handshake(2);
    end
    bodyValid <= 1'b0;
    if (!skip)
    begin
      late = dd.dataType[7:3] != GROUP_COMPUTER && rtc - dd.relTime >= GEN_TICKS;
      @(negedge clk);
      chk(ageAlarm, late);
    end
  endtask : sendPkt

  // Builds the expected packet, sends it and compares every output byte
  task automatic goodPkt(input desc_t dd, input logic [7:0] sq);
    int ckB;
    int fill;
    logic [15:0] s;
    ckB = (dd.ckSize == CK_32) ? 4 : int'(dd.ckSize);
    fill = (4 - ((24 + dd.dataLen + ckB) % 4)) % 4;
    s = 16'h0;
    expQ = {};
    put32({((dd.dataType == TYPE_SETUP) ? dd.channel : dd.channel | muxExp), SYNC_WORD});
    put32(32'(24 + dd.dataLen + fill + ckB));
    put32(dd.dataLen);
    put32({dd.dataType, dd.flags & ~FLAG_RSVD_MASK, sq, dd.version});
    put32(dd.relTime[31:0]);
    expQ.push_back(dd.relTime[39:32]);
    expQ.push_back(dd.relTime[47:40]);
    for (int k = 0; k < 11; k++)
      s = s + {expQ[2*k+1], expQ[2*k]};
    expQ.push_back(s[7:0]);
    expQ.push_back(s[15:8]);
    for (int i = 0; i < dd.dataLen; i++)
      expQ.push_back(8'(i) ^ 8'h5a);
    for (int i = 0; i < fill; i++)
      expQ.push_back(8'h00);
    put32(32'h8a3c_51e7);
    expQ = expQ[0:expQ.size()-5+ckB];
    sendPkt(dd, 1'b0);
    handshake(3);
    chk(consumer.rxQ.size(), expQ.size());
    foreach (expQ[i])
      chk({consumer.rxQ[i].last, consumer.rxQ[i].data}, {i == expQ.size()-1, expQ[i]});
    consumer.rxQ = {};
  endtask : goodPkt

  // A refused descriptor emits nothing and raises its error bit
  task automatic refuse(input desc_t dd, input int b);
    sendPkt(dd, 1'b1);
    repeat (3) @(posedge clk);
    chk(consumer.rxQ.size(), 0);
    ahb(1'b0, REG_ERRORS, 32'h0);
    chk(snap[b], 1'b1);
    ahb(1'b1, REG_ERRORS, 32'hffff_ffff);
  endtask : refuse

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(REG_CTRL, 32'h0);
    rdChk(REG_STATUS, 32'h0);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    rdChk(8'h40, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h3);
    rdChk(REG_CTRL, 32'h3);
    refuse(mk(8'h11, 16'h0001, 8'h06, 32'h4, CK_8), ERR_ORDER);
    goodPkt(mk(TYPE_SETUP, 16'h0000, 8'h06, 32'h5, CK_32), 8'h00);
    slow <= 1'b1;
    goodPkt(mk(TYPE_SETUP, 16'h0000, 8'h06, 32'h6, CK_16), 8'h01);
    slow <= 1'b0;
    refuse(mk(TYPE_SETUP, 16'h0000, 8'h00, 32'h4, CK_8), ERR_VERSION);
    refuse(mk(8'h11, 16'h0000, 8'h06, 32'h4, CK_8), ERR_CHANNEL);
    d = mk(8'h11, 16'h0001, 8'h06, 32'h3, CK_8);
    d.flags = 8'h10;
    goodPkt(d, 8'h00);
    refuse(mk(8'h19, 16'h0002, 8'h06, 32'h0, CK_16), ERR_EMPTY);
    refuse(mk(TYPE_SETUP, 16'h0000, 8'h06, 32'h4, CK_8), ERR_ORDER);
    refuse(mk(8'h19, 16'h0003, 8'h06, 32'h0008_0000, CK_16), ERR_SIZE);
    refuse(mk(8'h11, 16'h0001, 8'h05, 32'h4, CK_8), ERR_VERSION);
    ahb(1'b1, REG_MUX, 32'ha000_0004);
    rdChk(REG_MUX, 32'ha000_0004);
    muxExp = 16'ha000;
    rtc <= 48'h0000_0100_0000;
    d = mk(8'h19, 16'h0005, 8'h06, 32'h4, CK_16);
    d.relTime = 48'h0;
    goodPkt(d, 8'h00);
    rdChk(REG_ERRORS, 32'h0000_0060);
    goodPkt(mk(TYPE_INDEX, 16'h0002, 8'h06, 32'h4, CK_NONE), 8'h00);
    refuse(mk(8'h19, 16'h0004, 8'h06, 32'h4, CK_16), ERR_ORDER);
    rdChk(REG_STATUS, 32'h3);
    rdChk(REG_PKTCOUNT, 32'h5);
    tally_and_finish();
  end
endmodule : recorder_packet_framer_tb
